//--- inc/sdram_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the SDRAM core.
// Assumes: One 20 MHz clock; every pin but RESETN is sampled on its rising edge.
// Notes: Timing figures are in clocks of the device clock.
`ifndef SDRAM_MAP_SVH
`define SDRAM_MAP_SVH
`define COL_TO_COL_GAP 1
`define GATE_LOW_TO_SUSPEND 1
`define GATE_HIGH_TO_RESUME 1
`define MASK_TO_WRITE_MASK 0
`define MASK_TO_READ_FLOAT 2
`define WRITE_TO_DATA_DELAY 0
`define MODE_LOAD_TO_COMMAND 2
// Worst case over all latencies, so one figure serves every mode.
`define LAST_DATA_TO_ACTIVATE 5
`define DATA_TO_PRECHARGE 3
`define AUTO_PRECHARGE_BIT 10
`define MODE_BLEN_LSB 0
`define MODE_LAT_LSB 4
`define RST_READ_LATENCY 2'h2
`define RST_BLEN_CODE 3'h0
`define BLEN_PAGE 3'h7
`endif

//--- inc/sdram_pkg.sv
// Purpose: Types shared by the SDRAM core.
// Assumes: Strobe order chip select, row, column, write enable.
// Notes: Timing and field figures live in sdram_map.svh.
package sdram_pkg;
   // Command code is {cs, row strobe, column strobe, write enable}, all active low.
   typedef enum logic [3:0] {
      CMD_LMR = 4'h0, CMD_REF = 4'h1, CMD_PRE = 4'h2, CMD_ACT = 4'h3,
      CMD_WR = 4'h4, CMD_RD = 4'h5, CMD_BST = 4'h6, CMD_NOP = 4'h7
   } cmd_e;
   // Burst engine modes.
   typedef enum logic [1:0] {BURST_IDLE = 2'h0, BURST_READ = 2'h1, BURST_WRITE = 2'h2} burst_e;
   typedef logic [31:0] word_t;
endpackage

//--- hw/sdram_fifo2.sv
// Purpose: Two-entry buffer between the read pipeline and the data pins.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Both sides stall during clock suspend, so the buffer never fills.
`timescale 1ns/1ps
module sdram_fifo2
   import sdram_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire word_t in_data,
   output logic out_valid,
   input wire logic out_ready,
   output word_t out_data
);
   // Whole state: two slots, read pointer and fill count.
   typedef struct packed {
      logic [1:0][31:0] slot;
      logic rp;
      logic [1:0] cnt;
   } fifo_s;
   fifo_s q, d;

   // Ready and valid follow the fill count honestly.
   assign in_ready = (q.cnt != 2'h2);
   assign out_valid = (q.cnt != 2'h0);
   assign out_data = q.slot[q.rp];

   // Next state: push at write slot, pop advances the read pointer.
   always_comb
   begin
      logic push;
      logic pop;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      d = q;
      if (push)
      begin
         d.slot[q.rp ^ q.cnt[0]] = in_data;
      end
      if (pop)
      begin
         d.rp = ~q.rp;
      end
      d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // A full buffer must refuse new words.
   a_fifo_full_refuse: assert property (@(posedge clk) disable iff (!rst_n)
      (q.cnt == 2'h2) |-> !in_ready)
      else $error("Buffer accepts while full.");
endmodule

//--- hw/sdram_core.sv
// Purpose: Command decode, bank state, burst engine and data path of a four-bank SDRAM.
// Assumes: The controller keeps all command spacings; inputs share CLK with it.
// Notes: Burst order is sequential wrap only; mode fields are burst code and latency.
`timescale 1ns/1ps
`include "sdram_map.svh"
module sdram_core
   import sdram_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CKE,
   input wire logic CS_N,
   input wire logic RAS_N,
   input wire logic CAS_N,
   input wire logic WE_N,
   input wire logic [1:0] BA,
   input wire logic [11:0] ADDR,
   input wire logic [3:0] DQM,
   input wire logic [31:0] DQ_I,
   output logic [31:0] DQ_O,
   output logic [3:0] DQ_OE
);
   // Complete register state of the core.
   typedef struct packed {
      logic cke;                  // Clock enable as sampled last edge.
      logic [1:0] lat;            // Read latency 1..3.
      logic [2:0] blen;           // Burst length code.
      logic [3:0] act;            // Open-row flag per bank.
      logic [3:0][11:0] row;      // Open row per bank.
      burst_e mode;               // Burst engine mode.
      logic [1:0] bank;           // Bank of running burst.
      logic [7:0] col;            // Start column of running burst.
      logic [7:0] ofs;            // Beat offset inside the burst.
      logic [8:0] rem;            // Beats still to run.
      logic ap;                   // Auto precharge at burst end.
      logic [1:0] pv;             // Read pipeline valid per stage.
      logic [1:0][31:0] pd;       // Read pipeline data per stage.
      logic [3:0] dqm1;           // Read mask, one clock old.
      logic [3:0] dqm2;           // Read mask, two clocks old.
   } core_s;
   core_s q, d;

   cmd_e cmd;                     // Decoded command.
   logic run;                     // Device clock not suspended.
   logic step;                    // Engine may advance this edge.
   logic rd_cmd, wr_cmd;          // Column commands taken this edge.
   logic beat;                    // A burst beat happens this edge.
   logic [1:0] beat_bank;         // Bank of this beat.
   logic [7:0] beat_col;          // Column of this beat.
   logic [7:0] wrap;              // Wrap mask of the burst length.
   logic [21:0] beat_addr;        // Array index of this beat.
   logic rd_beat, wr_beat;        // Beat kind.
   word_t rd_word;                // Array word for a read beat.
   logic buf_in_valid, buf_in_ready, buf_out_valid;
   word_t buf_in_data, buf_out_data;

   // Inhibit decodes as NOP; the four strobes form the command code.
   assign cmd = CS_N ? CMD_NOP : cmd_e'({1'b0, RAS_N, CAS_N, WE_N});
   // Suspend takes effect one clock after low clock enable is sampled.
   assign run = q.cke;
   // A full buffer holds the engine so no read word is dropped.
   assign step = run && buf_in_ready;
   assign rd_cmd = step && (cmd == CMD_RD);
   assign wr_cmd = step && (cmd == CMD_WR);
   assign beat = rd_cmd || wr_cmd || (step && (q.mode != BURST_IDLE));
   assign rd_beat = beat && (rd_cmd || (!wr_cmd && q.mode == BURST_READ));
   assign wr_beat = beat && !rd_beat;
   assign beat_bank = (rd_cmd || wr_cmd) ? BA : q.bank;

   // Wrap mask of each burst length code; page bursts run the whole row.
   always_comb
   begin
      case (q.blen)
         3'h0: wrap = 8'h00;
         3'h1: wrap = 8'h01;
         3'h2: wrap = 8'h03;
         3'h3: wrap = 8'h07;
         default: wrap = 8'hff;
      endcase
   end

   // Sequential wrap order inside the aligned burst block.
   assign beat_col = (rd_cmd || wr_cmd) ? ADDR[7:0] :
      ((q.col & ~wrap) | ((q.col + q.ofs) & wrap));
   assign beat_addr = {beat_bank, q.row[beat_bank], beat_col};
   // Latency one feeds the buffer directly, otherwise the last pipe stage does.
   assign buf_in_valid = run && ((q.lat == 2'h1) ? rd_beat : q.pv[0]);
   assign buf_in_data = (q.lat == 2'h1) ? rd_word : q.pd[0];

   sdram_fifo2 u_fifo (
      .clk(CLK),
      .rst_n(RESETN),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(buf_in_data),
      .out_valid(buf_out_valid),
      .out_ready(run),
      .out_data(buf_out_data)
   );

   // Pins: data from buffer flops, lanes floated by the two-clock-old mask.
   assign DQ_O = buf_out_data;
   assign DQ_OE = {4{buf_out_valid}} & ~q.dqm2;

   // Next-state logic of the whole core.
   always_comb
   begin
      logic [8:0] left;
      logic done;
      left = 9'h0;
      done = 1'b0;
      d = q;
      d.cke = CKE;
      if (run)
      begin
         // Mask chain advances with the device clock only.
         d.dqm1 = DQM;
         d.dqm2 = q.dqm1;
      end
      if (step)
      begin
         // Pipeline moves one stage toward the buffer.
         d.pv = {1'b0, q.pv[1]};
         d.pd[0] = q.pd[1];
         d.pv[1] = 1'b0;
         if (rd_beat && q.lat == 2'h3)
         begin
            d.pv[1] = 1'b1;
            d.pd[1] = rd_word;
         end
         else if (rd_beat && q.lat == 2'h2)
         begin
            d.pv[0] = 1'b1;
            d.pd[0] = rd_word;
         end
         // Beat bookkeeping; page bursts never count down.
         if (beat)
         begin
            left = ((rd_cmd || wr_cmd) ? ({1'b0, wrap} + 9'h1) : q.rem) - 9'h1;
            if (q.blen == `BLEN_PAGE)
            begin
               left = 9'h1;
            end
            d.rem = left;
            d.ofs = (rd_cmd || wr_cmd) ? 8'h01 : q.ofs + 8'h01;
            d.mode = (left == 9'h0) ? BURST_IDLE : d.mode;
            done = (left == 9'h0);
         end
         // Decode of commands sampled this edge.
         case (cmd)
            CMD_ACT:
            begin
               d.act[BA] = 1'b1;
               d.row[BA] = ADDR;
            end
            CMD_RD, CMD_WR:
            begin
               d.mode = (cmd == CMD_RD) ? BURST_READ : BURST_WRITE;
               d.mode = done ? BURST_IDLE : d.mode;
               d.bank = BA;
               d.col = ADDR[7:0];
               d.ap = ADDR[`AUTO_PRECHARGE_BIT];
            end
            CMD_PRE:
            begin
               // Precharge ends a running burst after this edge's beat.
               d.mode = BURST_IDLE;
               done = 1'b0;
               if (ADDR[`AUTO_PRECHARGE_BIT])
               begin
                  d.act = 4'h0;
               end
               else
               begin
                  d.act[BA] = 1'b0;
               end
            end
            CMD_BST:
            begin
               d.mode = BURST_IDLE;
               done = 1'b0;
            end
            CMD_LMR:
            begin
               d.blen = ADDR[`MODE_BLEN_LSB +: 3];
               if (ADDR[`MODE_LAT_LSB +: 2] != 2'h0)
               begin
                  d.lat = ADDR[`MODE_LAT_LSB +: 2];
               end
            end
            default:
            begin
               // Refresh and NOP change no core state.
               d.mode = d.mode;
            end
         endcase
         // A burst that ends by itself closes its row when asked to.
         if (done && d.ap)
         begin
            d.act[d.bank] = 1'b0;
         end
      end
   end

   // State register.
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         q <= '0;
         q.lat <= `RST_READ_LATENCY;
         q.blen <= `RST_BLEN_CODE;
         q.mode <= BURST_IDLE;
      end
      else
      begin
         q <= d;
      end
   end

   // Byte lanes of a write beat, masked by the same-clock mask.
   // Each lane owns its byte array, so every array has exactly one writer.
   for (genvar g = 0; g < 4; g++)
   begin : g_lane
      // Lane bytes of 4 banks x 4096 rows x 256 columns.
      logic [7:0] lane_mem [0:4194303];
      assign rd_word[8*g +: 8] = lane_mem[beat_addr];
      always_ff @(posedge CLK)
      begin
         if (wr_beat && !DQM[g])
         begin
            lane_mem[beat_addr] <= DQ_I[8*g +: 8];
         end
      end
   end

   a_suspend_freeze: assert property (@(posedge CLK) disable iff (!RESETN)
      !CKE |=> ##1 ($stable(q.ofs) && $stable(q.pv)))
      else $error("State moved during suspend.");
   a_resume_moves: assert property (@(posedge CLK) disable iff (!RESETN)
      (CKE && !q.cke) |=> (run && (!buf_in_ready || beat == ((cmd == CMD_RD) ||
      (cmd == CMD_WR) || q.mode != BURST_IDLE))))
      else $error("Beat not taken after resume.");
   a_read_float: assert property (@(posedge CLK) disable iff (!RESETN)
      (run && $past(run)) |-> ((DQ_OE & $past(q.dqm1)) == 4'h0))
      else $error("Masked lane driven.");
   a_write_lanes: assert property (@(posedge CLK) disable iff (!RESETN)
      (step && cmd == CMD_WR) |-> wr_beat && beat_addr[7:0] == ADDR[7:0])
      else $error("Write beat missing with command.");
   a_act_row: assert property (@(posedge CLK) disable iff (!RESETN)
      (step && cmd == CMD_ACT) |=> (q.act[$past(BA)] && q.row[$past(BA)] == $past(ADDR)))
      else $error("Row not opened.");
   a_pre_all: assert property (@(posedge CLK) disable iff (!RESETN)
      (step && cmd == CMD_PRE && ADDR[10]) |=> (q.act == 4'h0))
      else $error("Banks left open.");
   a_pre_stop: assert property (@(posedge CLK) disable iff (!RESETN)
      (step && cmd == CMD_PRE) |=> (q.mode == BURST_IDLE) ##2 (q.pv == 2'h0 || !run ||
      !buf_in_ready || $past(rd_beat) || $past(rd_beat, 2)))
      else $error("Burst ran past precharge.");
   a_col_start: assert property (@(posedge CLK) disable iff (!RESETN)
      (step && (cmd == CMD_RD || cmd == CMD_WR)) |=> (q.col == $past(ADDR[7:0]) &&
      q.ap == $past(ADDR[10])))
      else $error("Start column or precharge flag wrong.");
   a_burst_two: assert property (@(posedge CLK) disable iff (!RESETN)
      (step && cmd == CMD_RD && q.blen == 3'h1) |=> (q.mode == BURST_READ && q.rem == 9'h1))
      else $error("Burst of two not running.");
endmodule

//--- bench/sdram_host_model.sv
// Purpose: Controller stand-in that drives command, mask and write data pins.
// Assumes: Pins change just after a rising edge and hold for one clock.
// Notes: Idle write data lines show the inverse of their last value.
`timescale 1ns/1ps
`include "sdram_map.svh"
module sdram_host_model
   import sdram_pkg::*;
(
   input wire logic clk,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [1:0] ba,
   output logic [11:0] addr,
   output logic [3:0] dqm,
   output word_t dq_i
);
   logic ce_v = 1'b0; // Clock-enable level for the next slot.
   int gap = 0; // Slots still owed after a mode load.
   int since = 99; // Slots since the last write data word.
   // Quiet pins at time zero, device left suspended.
   initial
   begin
      cke = 1'b0;
      {cs_n, ras_n, cas_n, we_n} = CMD_NOP;
      ba = 2'h0;
      addr = 12'h000;
      dqm = 4'h0;
      dq_i = 32'h0000_0000;
   end
   // Sets the clock-enable level used from the next slot on.
   task automatic gate(input logic v);
      ce_v = v;
   endtask
   // One command slot; a refresh or activation first waits out the mode-load gap.
   task automatic issue(input cmd_e c, input logic [1:0] b, input logic [11:0] a,
      input logic [3:0] m, input word_t d, input logic w);
      @(posedge clk);
      if (gap > 0)
         gap--;
      since++;
      // Stop and column commands need one slot after data, which every issue gives.
      while ((gap > 0 && (c == CMD_ACT || c == CMD_REF)) ||
         (since < `DATA_TO_PRECHARGE && c == CMD_PRE) ||
         (since < `LAST_DATA_TO_ACTIVATE && c == CMD_ACT))
      begin
         {cs_n, ras_n, cas_n, we_n} <= CMD_NOP;
         dq_i <= ~dq_i;
         @(posedge clk);
         if (gap > 0)
            gap--;
         since++;
      end
      cke <= ce_v;
      {cs_n, ras_n, cas_n, we_n} <= c;
      ba <= b;
      addr <= a;
      dqm <= m;
      dq_i <= w ? d : ~dq_i;
      if (w)
         since = 0;
      if (c == CMD_LMR)
         gap = `MODE_LOAD_TO_COMMAND;
   endtask
endmodule

//--- bench/testbench.sv
// Purpose: Self-checking bench for the SDRAM core.
// Assumes: 20 MHz clock; the host model keeps all command spacings.
// Notes: Bursts use bank 2 row abc; the read window is checked one clock on each side.
`timescale 1ns/1ps
module testbench
   import sdram_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic cke, cs_n, ras_n, cas_n, we_n;
   logic [1:0] ba;
   logic [11:0] addr;
   logic [3:0] dqm, dq_oe;
   word_t dq_i, dq_o;
   int fail_count = 0;
   int n_checks = 0;
   int cl = 2; // Read latency last programmed.
   // Clock of 50 ns; kept steady throughout.
   always #25 clk = ~clk;
   sdram_core i_sdram_core (.CLK(clk), .RESETN(resetn), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
      .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .ADDR(addr), .DQM(dqm), .DQ_I(dq_i), .DQ_O(dq_o),
      .DQ_OE(dq_oe));
   sdram_host_model host (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_i(dq_i));
   // Compares one value and counts it.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Prints the verdict and stops.
   task automatic give_verdict();
      if (fail_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Closes all banks, then loads latency c and burst code b.
   task automatic set_mode(input int c, input logic [2:0] b);
      host.issue(CMD_PRE, 2'h1, 12'h400, 4'h0, 32'h0, 1'b0);
      host.issue(CMD_LMR, 2'h0, {6'h00, c[1:0], 1'b0, b}, 4'h0, 32'h0, 1'b0);
      cl = c;
      host.issue(CMD_ACT, 2'h2, 12'habc, 4'h0, 32'h0, 1'b0);
   endtask
   // Two-beat write; m holds one mask nibble per beat.
   task automatic wr(input logic [7:0] col, input logic [7:0] m, input word_t d0, input word_t d1);
      host.issue(CMD_WR, 2'h2, {4'h0, col}, m[3:0], d0, 1'b1);
      host.issue(CMD_NOP, 2'h2, 12'h000, m[7:4], d1, 1'b1);
   endtask
   // Read of n beats; m is a mask nibble per issued slot; lanes are idle around the window.
   task automatic rd(input logic [7:0] col, input int n, input logic [31:0] m, input word_t e0,
      input word_t e1);
      logic [3:0] oe;
      word_t lane;
      int j;
      int mi;
      host.issue(CMD_RD, 2'h2, {4'h4, col}, m[3:0], 32'h0, 1'b0);
      j = 1;
      repeat (cl - 1)
      begin
         host.issue(CMD_NOP, 2'h2, 12'h000, m[4*j +: 4], 32'h0, 1'b0);
         j++;
      end
      for (int i = -1; i <= n; i++)
      begin
         if (i >= 0)
         begin
            host.issue(CMD_NOP, 2'h2, 12'h000, m[4*j +: 4], 32'h0, 1'b0);
            j++;
         end
         #1;
         mi = i + cl - 2;
         oe = (i < 0 || i >= n) ? 4'h0 : ~((mi >= 0) ? m[4*mi +: 4] : 4'h0);
         lane = {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
         check("read lanes", {28'h0, dq_oe}, {28'h0, oe});
         check("read data", dq_o & lane, (i == 0 ? e0 : e1) & lane);
      end
   endtask
   // Start-up pause of 100 us, then two refreshes.
   task automatic init_seq();
      host.gate(1'b1);
      repeat (2000) host.issue(CMD_NOP, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
      // The run stays far inside one refresh interval, so one wake-up pair suffices.
      repeat (2)
      begin
         host.issue(CMD_REF, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
         host.issue(CMD_NOP, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
      end
   endtask
   // Write burst wraps in its block; a read follows the last word at once.
   task automatic t_burst();
      set_mode(2, 3'h1);
      wr(8'h03, 8'h00, 32'h1111_2222, 32'h3333_4444);
      rd(8'h02, 2, 32'h0, 32'h3333_4444, 32'h1111_2222);
   endtask
   // Byte masks on a write, then a late mask that floats the low two lanes of the second read beat.
   task automatic t_mask();
      wr(8'h02, 8'hf5, 32'hffff_ffff, 32'h0);
      rd(8'h02, 2, 32'h0000_0030, 32'hff33_ff44, 32'h1111_2222);
   endtask
   // A read in the clock after clock-enable drops is ignored; the next one runs.
   task automatic t_suspend();
      host.gate(1'b0);
      host.issue(CMD_NOP, 2'h2, 12'h000, 4'h0, 32'h0, 1'b0);
      host.gate(1'b1);
      host.issue(CMD_RD, 2'h2, 12'h003, 4'h0, 32'h0, 1'b0);
      rd(8'h03, 2, 32'h0, 32'h1111_2222, 32'hff33_ff44);
   endtask
   // Single-beat reads at every latency.
   task automatic t_latency();
      for (int c = 1; c <= 3; c++)
      begin
         set_mode(c, 3'h0);
         rd(8'h03, 1, 32'h0, 32'h1111_2222, 32'h0);
      end
   endtask
   // Main sequence after eight clocks of reset.
   initial
   begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      init_seq();
      t_burst();
      t_mask();
      t_suspend();
      t_latency();
      give_verdict();
   end
   // Cuts a hang short; the tests need under 2300 clocks.
   initial
   begin
      repeat (6000) @(posedge clk);
      fail_count++;
      give_verdict();
   end
endmodule
